// *** inc/acc_pkg.sv ***
// Package: register map, field positions and reset values of the comparator control block
`default_nettype none

package acc_pkg;

	// Register addresses, shared by all instances
	localparam logic [7:0] ADDR_CTRL = 8'h88;
	localparam logic [7:0] ADDR_MODE = 8'h89;

	// Page of instance 0; instance n sits on page PAGE_BASE + n
	localparam logic [7:0] PAGE_BASE = 8'h01;

	// Control register field positions
	localparam int CTRL_EN_BIT = 7;
	localparam int CTRL_OUT_BIT = 6;
	localparam int CTRL_RIF_BIT = 5;
	localparam int CTRL_FIF_BIT = 4;
	localparam int CTRL_HYP_LSB = 2;
	localparam int CTRL_HYN_LSB = 0;

	// Mode register field positions
	localparam int MODE_RIE_BIT = 5;
	localparam int MODE_FIE_BIT = 4;
	localparam int MODE_SPD_LSB = 0;

	// Width of the two-bit select fields
	localparam int SEL_W = 2;

	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h02;
	localparam logic [7:0] READ_IDLE = 8'h00;

	// Hysteresis codes
	typedef enum logic [1:0] {
		HYST_OFF,
		HYST_5MV,
		HYST_10MV,
		HYST_20MV
	} acc_hyst_e;

	// Response modes, fastest to lowest power
	typedef enum logic [1:0] {
		SPD_MODE0,
		SPD_MODE1,
		SPD_MODE2,
		SPD_MODE3
	} acc_speed_e;

endpackage

`default_nettype wire

// *** rtl/acc_sync.sv ***
// Two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module acc_sync #(
	parameter int WIDTH = 3
) (
	input wire logic clk, // System clock
	input wire logic nrst, // Asynchronous reset, active low
	input wire logic [WIDTH-1:0] asyncIn, // Asynchronous levels
	output logic [WIDTH-1:0] syncOut // Levels in the clock domain
);

	logic [WIDTH-1:0] stage1_r;
	logic [WIDTH-1:0] stage2_r;

	// First stage feeds only the second stage
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stage1_r <= '0;
			stage2_r <= '0;
		end else begin
			stage1_r <= asyncIn;
			stage2_r <= stage1_r;
		end
	end

	assign syncOut = stage2_r;

endmodule // acc_sync

`default_nettype wire

// *** rtl/acc_flag.sv ***
// Sticky event flag: hardware set wins over a software write in the same cycle
`timescale 1ns/1ps
`default_nettype none

module acc_flag (
	input wire logic clk, // System clock
	input wire logic nrst, // Asynchronous reset, active low
	input wire logic setPulse, // Hardware event, one cycle
	input wire logic wrEn, // Software write to the flag
	input wire logic wrVal, // Value written
	output logic flag // Flag state
);

	logic flag_r;

	// Event sets; a write loads its value unless an event arrives together
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flag_r <= 1'b0;
		end else if (setPulse) begin
			flag_r <= 1'b1;
		end else if (wrEn) begin
			flag_r <= wrVal;
		end
	end

	assign flag = flag_r;

endmodule // acc_flag

`default_nettype wire

// *** rtl/acc_top.sv ***
// Control and status registers for a set of analog comparators on the paged register port
//
// Functional notes
// - control bit 7 powers the comparator
// - control bit 6 reads live result
// - rising edge sets sticky flag, software clears
// - falling edge sets sticky flag, software clears
// - control bits 3-2 drive positive hysteresis
// - control bits 1-0 drive negative hysteresis
// - mode bit 5 gates rising-edge interrupt
// - mode bit 4 gates falling-edge interrupt
// - mode bits 1-0 select response speed
// - unused mode bits read zero, ignore writes
// - control 0x88, mode 0x89, pages 1-3
// - disabled comparator drives its pin low
// - interrupt also needs extended enable bit
`timescale 1ns/1ps
`default_nettype none

module acc_top #(
	parameter int NUM_CMP = 3
) (
	input wire logic clk, // System clock, 10 MHz
	input wire logic nrst, // Asynchronous reset, active low
	input wire logic [7:0] sfrAddr, // Register address
	input wire logic [7:0] sfrPage, // Register page
	input wire logic [7:0] sfrWrData, // Write data
	input wire logic sfrWe, // Write strobe
	input wire logic sfrRe, // Read strobe
	output logic [7:0] sfrRdData, // Read data, valid the cycle after the strobe
	output logic sfrRdHit, // Last read hit a register of this block
	input wire logic [NUM_CMP-1:0] compareRaw, // Analog comparator outputs, asynchronous
	input wire logic cmpIrqGlobalEn, // Comparator bit of the extended interrupt enable
	output logic [NUM_CMP-1:0] compareEnable, // Power-on per comparator
	output logic [2*NUM_CMP-1:0] posHystSelect, // Positive hysteresis, two bits each
	output logic [2*NUM_CMP-1:0] negHystSelect, // Negative hysteresis, two bits each
	output logic [2*NUM_CMP-1:0] responseSpeedSelect, // Response mode, two bits each
	output logic [NUM_CMP-1:0] comparePinOut, // Result routed to the port pin
	output logic [NUM_CMP-1:0] compareIrq // Edge interrupt request per comparator
);

	// Register state
	logic [NUM_CMP-1:0] compareEnable_r;
	logic [NUM_CMP-1:0][1:0] posHyst_r;
	logic [NUM_CMP-1:0][1:0] negHyst_r;
	logic [NUM_CMP-1:0] riseIrqEnable_r;
	logic [NUM_CMP-1:0] fallIrqEnable_r;
	logic [NUM_CMP-1:0][1:0] speed_r;

	// Edge detection state
	logic [NUM_CMP-1:0] compareResult;
	logic [NUM_CMP-1:0] resultPrev_r;
	logic [NUM_CMP-1:0] armed_r;
	logic [NUM_CMP-1:0] risePulse;
	logic [NUM_CMP-1:0] fallPulse;
	logic [NUM_CMP-1:0] riseEventFlag;
	logic [NUM_CMP-1:0] fallEventFlag;

	// Decode
	logic [NUM_CMP-1:0] ctrlSel;
	logic [NUM_CMP-1:0] modeSel;
	logic [NUM_CMP-1:0] ctrlWr;
	logic [NUM_CMP-1:0] modeWr;

	// Outputs
	logic [7:0] rdData_r;
	logic [7:0] rdData_nxt;
	logic rdHit_r;
	logic rdHit_nxt;
	logic [NUM_CMP-1:0] pinOut_r;
	logic [NUM_CMP-1:0] irq_r;
	logic [NUM_CMP-1:0] irq_nxt;

	// Bring the analog results into the clock domain
	acc_sync #(
		.WIDTH(NUM_CMP)
	) u_sync (
		.clk(clk),
		.nrst(nrst),
		.asyncIn(compareRaw),
		.syncOut(compareResult)
	);

	// Page and address decode; instance n sits on page base plus n
	always_comb begin
		for (int i = 0; i < NUM_CMP; i++) begin
			ctrlSel[i] = (sfrAddr == acc_pkg::ADDR_CTRL) &&
				(sfrPage == acc_pkg::PAGE_BASE + 8'(i));
			modeSel[i] = (sfrAddr == acc_pkg::ADDR_MODE) &&
				(sfrPage == acc_pkg::PAGE_BASE + 8'(i));
			ctrlWr[i] = sfrWe && ctrlSel[i];
			modeWr[i] = sfrWe && modeSel[i];
		end
	end

	// Comparator enable
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			compareEnable_r <= '0;
		end else begin
			for (int i = 0; i < NUM_CMP; i++) begin
				if (ctrlWr[i]) begin
					compareEnable_r[i] <= sfrWrData[acc_pkg::CTRL_EN_BIT];
				end
			end
		end
	end

	// Positive hysteresis select
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			posHyst_r <= '0;
		end else begin
			for (int i = 0; i < NUM_CMP; i++) begin
				if (ctrlWr[i]) begin
					posHyst_r[i] <= sfrWrData[acc_pkg::CTRL_HYP_LSB +: acc_pkg::SEL_W];
				end
			end
		end
	end

	// Negative hysteresis select
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			negHyst_r <= '0;
		end else begin
			for (int i = 0; i < NUM_CMP; i++) begin
				if (ctrlWr[i]) begin
					negHyst_r[i] <= sfrWrData[acc_pkg::CTRL_HYN_LSB +: acc_pkg::SEL_W];
				end
			end
		end
	end

	// Edge interrupt enables; unused mode bits are not stored
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			riseIrqEnable_r <= '0;
			fallIrqEnable_r <= '0;
		end else begin
			for (int i = 0; i < NUM_CMP; i++) begin
				if (modeWr[i]) begin
					riseIrqEnable_r[i] <= sfrWrData[acc_pkg::MODE_RIE_BIT];
					fallIrqEnable_r[i] <= sfrWrData[acc_pkg::MODE_FIE_BIT];
				end
			end
		end
	end

	// Response speed select, resets to mode 2
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_CMP; i++) begin
				speed_r[i] <= acc_pkg::MODE_RESET[acc_pkg::MODE_SPD_LSB +: acc_pkg::SEL_W];
			end
		end else begin
			for (int i = 0; i < NUM_CMP; i++) begin
				if (modeWr[i]) begin
					speed_r[i] <= sfrWrData[acc_pkg::MODE_SPD_LSB +: acc_pkg::SEL_W];
				end
			end
		end
	end

	// Edge tracking; armed only after a full enabled cycle so power-up and shutdown make no edges
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			resultPrev_r <= '0;
			armed_r <= '0;
		end else begin
			resultPrev_r <= compareResult;
			armed_r <= compareEnable_r;
		end
	end

	// Edge pulses from the synchronised result
	always_comb begin
		for (int i = 0; i < NUM_CMP; i++) begin
			risePulse[i] = armed_r[i] && compareEnable_r[i] && !resultPrev_r[i] && compareResult[i];
			fallPulse[i] = armed_r[i] && compareEnable_r[i] && resultPrev_r[i] && !compareResult[i];
		end
	end

	// Sticky flags, one pair per comparator
	for (genvar g = 0; g < NUM_CMP; g++) begin : gen_flags
		acc_flag u_rise (
			.clk(clk),
			.nrst(nrst),
			.setPulse(risePulse[g]),
			.wrEn(ctrlWr[g]),
			.wrVal(sfrWrData[acc_pkg::CTRL_RIF_BIT]),
			.flag(riseEventFlag[g])
		);
		acc_flag u_fall (
			.clk(clk),
			.nrst(nrst),
			.setPulse(fallPulse[g]),
			.wrEn(ctrlWr[g]),
			.wrVal(sfrWrData[acc_pkg::CTRL_FIF_BIT]),
			.flag(fallEventFlag[g])
		);
	end

	// Interrupt request: flag and its edge enable, qualified by the extended enable
	always_comb begin
		for (int i = 0; i < NUM_CMP; i++) begin
			irq_nxt[i] = cmpIrqGlobalEn &&
				((riseEventFlag[i] && riseIrqEnable_r[i]) ||
				(fallEventFlag[i] && fallIrqEnable_r[i]));
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_r <= '0;
		end else begin
			irq_r <= irq_nxt;
		end
	end

	// Pin output forced low while the comparator is shut down
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pinOut_r <= '0;
		end else begin
			pinOut_r <= compareEnable_r & compareResult;
		end
	end

	// Read multiplexer; unused mode bits read zero
	always_comb begin
		rdData_nxt = acc_pkg::READ_IDLE;
		rdHit_nxt = 1'b0;
		for (int i = 0; i < NUM_CMP; i++) begin
			if (ctrlSel[i]) begin
				rdHit_nxt = 1'b1;
				rdData_nxt[acc_pkg::CTRL_EN_BIT] = compareEnable_r[i];
				rdData_nxt[acc_pkg::CTRL_OUT_BIT] = compareResult[i];
				rdData_nxt[acc_pkg::CTRL_RIF_BIT] = riseEventFlag[i];
				rdData_nxt[acc_pkg::CTRL_FIF_BIT] = fallEventFlag[i];
				rdData_nxt[acc_pkg::CTRL_HYP_LSB +: acc_pkg::SEL_W] = posHyst_r[i];
				rdData_nxt[acc_pkg::CTRL_HYN_LSB +: acc_pkg::SEL_W] = negHyst_r[i];
			end
			if (modeSel[i]) begin
				rdHit_nxt = 1'b1;
				rdData_nxt[acc_pkg::MODE_RIE_BIT] = riseIrqEnable_r[i];
				rdData_nxt[acc_pkg::MODE_FIE_BIT] = fallIrqEnable_r[i];
				rdData_nxt[acc_pkg::MODE_SPD_LSB +: acc_pkg::SEL_W] = speed_r[i];
			end
		end
	end

	// Read data is captured on the strobe and held until the next read
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdData_r <= acc_pkg::READ_IDLE;
			rdHit_r <= 1'b0;
		end else if (sfrRe) begin
			rdData_r <= rdData_nxt;
			rdHit_r <= rdHit_nxt;
		end
	end

	// Output wiring, each straight from a flip-flop
	assign sfrRdData = rdData_r;
	assign sfrRdHit = rdHit_r;
	assign compareEnable = compareEnable_r;
	assign posHystSelect = posHyst_r;
	assign negHystSelect = negHyst_r;
	assign responseSpeedSelect = speed_r;
	assign comparePinOut = pinOut_r;
	assign compareIrq = irq_r;

endmodule // acc_top

`default_nettype wire

// *** testbench/acc_checker.sv ***
// Checker: port assertions for the comparator control block
`timescale 1ns/1ps
`default_nettype none

module acc_checker #(
	parameter int NUM_CMP = 3
) (
	input wire logic clk, // Clock
	input wire logic nrst, // Reset
	input wire logic [7:0] sfrAddr, // Address
	input wire logic [7:0] sfrPage, // Page
	input wire logic [7:0] sfrWrData, // Write data
	input wire logic sfrWe, // Write
	input wire logic sfrRe, // Read
	input wire logic [7:0] sfrRdData, // Read data
	input wire logic sfrRdHit, // Read hit
	input wire logic [NUM_CMP-1:0] compareRaw, // Raw result
	input wire logic cmpIrqGlobalEn, // Global enable
	input wire logic [NUM_CMP-1:0] compareEnable, // Enable
	input wire logic [2*NUM_CMP-1:0] posHystSelect, // Pos hyst
	input wire logic [2*NUM_CMP-1:0] negHystSelect, // Neg hyst
	input wire logic [2*NUM_CMP-1:0] responseSpeedSelect, // Speed
	input wire logic [NUM_CMP-1:0] comparePinOut, // Pin
	input wire logic [NUM_CMP-1:0] compareIrq // Irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// Writes to instance 0
	logic wrCtrl;
	logic wrMode;
	assign wrCtrl = sfrWe && sfrAddr == 8'h88 && sfrPage == 8'h01;
	assign wrMode = sfrWe && sfrAddr == 8'h89 && sfrPage == 8'h01;

	property p_en;
		wrCtrl |=> compareEnable[0] == $past(sfrWrData[7]);
	endproperty
	a_en: assert property (p_en) else $error("enable not loaded");
	property p_hyp;
		wrCtrl |=> posHystSelect[1:0] == $past(sfrWrData[3:2]);
	endproperty
	a_hyp: assert property (p_hyp) else $error("pos hyst wrong");
	property p_hyn;
		wrCtrl |=> negHystSelect[1:0] == $past(sfrWrData[1:0]);
	endproperty
	a_hyn: assert property (p_hyn) else $error("neg hyst wrong");
	property p_spd;
		wrMode |=> responseSpeedSelect[1:0] == $past(sfrWrData[1:0]);
	endproperty
	a_spd: assert property (p_spd) else $error("speed wrong");
	property p_miss;
		sfrRe && sfrAddr[7:1] != 7'h44 |=> !sfrRdHit && sfrRdData == 8'h00;
	endproperty
	a_miss: assert property (p_miss) else $error("unmapped read");
	property p_unused;
		sfrRe && sfrAddr == 8'h89 && sfrPage == 8'h02 |=> sfrRdHit && (sfrRdData & 8'hcc) == 8'h00;
	endproperty
	a_unused: assert property (p_unused) else $error("unused bits set");
	property p_pinOff;
		!compareEnable[0] ##1 !compareEnable[0] |-> !comparePinOut[0];
	endproperty
	a_pinOff: assert property (p_pinOff) else $error("pin not low");
	property p_pinRise;
		$rose(compareRaw[0]) && compareEnable[0] ##1 (compareEnable[0] && compareRaw[0])[*3] |-> comparePinOut[0];
	endproperty
	a_pinRise: assert property (p_pinRise) else $error("pin late");
	property p_pinFall;
		$fell(compareRaw[0]) ##1 (!compareRaw[0])[*3] |-> !comparePinOut[0];
	endproperty
	a_pinFall: assert property (p_pinFall) else $error("pin stuck");
	property p_gate;
		!cmpIrqGlobalEn [*2] |-> !compareIrq[0];
	endproperty
	a_gate: assert property (p_gate) else $error("irq ungated");
endmodule // acc_checker

`default_nettype wire

// *** testbench/test_analog_comparator_control.sv ***
// Testbench: register access and edge events of the comparator block
`timescale 1ns/1ps
`default_nettype none

module test_analog_comparator_control;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] sfrAddr = 8'h00;
	logic [7:0] sfrPage = 8'h00;
	logic [7:0] sfrWrData = 8'h00;
	logic sfrWe = 1'b0;
	logic sfrRe = 1'b0;
	// Comparator results, standing for pins already set up as analog inputs
	logic [2:0] compareRaw = 3'h0;
	logic cmpIrqGlobalEn = 1'b0;
	logic [7:0] sfrRdData;
	logic sfrRdHit;
	logic [2:0] compareEnable;
	logic [5:0] posHystSelect;
	logic [5:0] negHystSelect;
	logic [5:0] responseSpeedSelect;
	logic [2:0] comparePinOut;
	logic [2:0] compareIrq;
	int mismatches = 0;
	int samplesChecked = 0;
	int cycles = 0;
	// Comparator power-up wait, 10 us at 100 ns per cycle
	localparam int POWER_UP_CYCLES = 100;

	acc_top i_dut (.clk(clk), .nrst(nrst), .sfrAddr(sfrAddr), .sfrPage(sfrPage), .sfrWrData(sfrWrData),
		.sfrWe(sfrWe), .sfrRe(sfrRe), .sfrRdData(sfrRdData), .sfrRdHit(sfrRdHit), .compareRaw(compareRaw),
		.cmpIrqGlobalEn(cmpIrqGlobalEn), .compareEnable(compareEnable), .posHystSelect(posHystSelect),
		.negHystSelect(negHystSelect), .responseSpeedSelect(responseSpeedSelect),
		.comparePinOut(comparePinOut), .compareIrq(compareIrq));

	// Clock and hang guard
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			test_done();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
		@(posedge clk) #1;
		sfrAddr = a;
		sfrPage = p;
		sfrWrData = d;
		sfrWe = 1'b1;
		@(posedge clk) #1;
		sfrWe = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d, input logic h);
		@(posedge clk) #1;
		sfrAddr = a;
		sfrPage = p;
		sfrRe = 1'b1;
		@(posedge clk) #1;
		sfrRe = 1'b0;
		chk(sfrRdData, d);
		chk({7'h0, sfrRdHit}, {7'h0, h});
	endtask

	// Waits n cycles, then lets the edge settle
	task automatic pause(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic t_reset;
		for (int i = 1; i < 4; i++) begin
			rd(8'h88, i[7:0], 8'h00, 1'b1);
			rd(8'h89, i[7:0], 8'h02, 1'b1);
		end
		chk({2'h0, responseSpeedSelect}, 8'h2a);
	endtask

	task automatic t_regs;
		wr(8'h89, 8'h01, 8'hff);
		rd(8'h89, 8'h01, 8'h33, 1'b1);
		wr(8'h89, 8'h02, 8'hff);
		rd(8'h89, 8'h02, 8'h33, 1'b1);
		wr(8'h88, 8'h01, 8'h40);
		rd(8'h88, 8'h01, 8'h00, 1'b1);
		rd(8'h8a, 8'h01, 8'h00, 1'b0);
		rd(8'h88, 8'h00, 8'h00, 1'b0);
		rd(8'h89, 8'h04, 8'h00, 1'b0);
		wr(8'h88, 8'h04, 8'hff);
		chk({5'h0, compareEnable}, 8'h00);
	endtask

	task automatic t_cfg;
		logic [1:0] c;
		for (int k = 0; k < 4; k++) begin
			c = k[1:0];
			for (int i = 1; i < 4; i++) begin
				wr(8'h88, i[7:0], {4'h8, c, ~c});
				wr(8'h89, i[7:0], {6'h00, c});
			end
			chk({5'h0, compareEnable}, 8'h07);
			chk({2'h0, posHystSelect}, {2'h0, c, c, c});
			chk({2'h0, negHystSelect}, {2'h0, ~c, ~c, ~c});
			chk({2'h0, responseSpeedSelect}, {2'h0, c, c, c});
		end
		for (int i = 1; i < 4; i++) begin
			wr(8'h88, i[7:0], 8'h00);
		end
		chk({5'h0, compareEnable}, 8'h00);
	endtask

	task automatic t_edges;
		wr(8'h88, 8'h01, 8'h80);
		wr(8'h89, 8'h01, 8'h20);
		pause(POWER_UP_CYCLES);
		cmpIrqGlobalEn = 1'b1;
		compareRaw = 3'h1;
		pause(6);
		chk({5'h0, compareIrq}, 8'h01);
		chk({5'h0, comparePinOut}, 8'h01);
		rd(8'h88, 8'h01, 8'he0, 1'b1);
		wr(8'h88, 8'h01, 8'h80);
		pause(2);
		chk({5'h0, compareIrq}, 8'h00);
		compareRaw = 3'h0;
		pause(6);
		chk({5'h0, compareIrq}, 8'h00);
		rd(8'h88, 8'h01, 8'h90, 1'b1);
		wr(8'h89, 8'h01, 8'h10);
		pause(2);
		chk({5'h0, compareIrq}, 8'h01);
		cmpIrqGlobalEn = 1'b0;
		pause(2);
		chk({5'h0, compareIrq}, 8'h00);
		wr(8'h88, 8'h01, 8'h00);
		compareRaw = 3'h1;
		pause(6);
		chk({5'h0, comparePinOut}, 8'h00);
		rd(8'h88, 8'h01, 8'h40, 1'b1);
		compareRaw = 3'h0;
		pause(4);
	endtask

	// Edges on the last instance, reached through its own page
	task automatic t_inst2;
		wr(8'h88, 8'h03, 8'h80);
		wr(8'h89, 8'h03, 8'h30);
		pause(POWER_UP_CYCLES);
		cmpIrqGlobalEn = 1'b1;
		compareRaw = 3'h4;
		pause(6);
		chk({5'h0, compareIrq}, 8'h04);
		chk({5'h0, comparePinOut}, 8'h04);
		rd(8'h88, 8'h03, 8'he0, 1'b1);
		compareRaw = 3'h0;
		pause(6);
		rd(8'h88, 8'h03, 8'hb0, 1'b1);
		wr(8'h88, 8'h03, 8'h00);
		cmpIrqGlobalEn = 1'b0;
		pause(2);
		chk({5'h0, compareIrq}, 8'h00);
	endtask

	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", samplesChecked, mismatches);
		if (mismatches == 0 && samplesChecked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		pause(5);
		nrst = 1'b1;
		t_reset();
		t_regs();
		t_cfg();
		t_edges();
		t_inst2();
		test_done();
	end
endmodule // test_analog_comparator_control

bind acc_top acc_checker #(.NUM_CMP(NUM_CMP)) i_chk (.clk(clk), .nrst(nrst), .sfrAddr(sfrAddr),
	.sfrPage(sfrPage), .sfrWrData(sfrWrData), .sfrWe(sfrWe), .sfrRe(sfrRe), .sfrRdData(sfrRdData),
	.sfrRdHit(sfrRdHit), .compareRaw(compareRaw), .cmpIrqGlobalEn(cmpIrqGlobalEn),
	.compareEnable(compareEnable), .posHystSelect(posHystSelect), .negHystSelect(negHystSelect),
	.responseSpeedSelect(responseSpeedSelect), .comparePinOut(comparePinOut), .compareIrq(compareIrq));

`default_nettype wire
